// [bench/sscl_host.sv]
// Model of the host that shifts control words into the latch.
`timescale 1ns/1ps
`default_nettype none
module sscl_host (
    output var logic sck,
    output var logic sdata,
    output var logic latch
);
    initial begin
        sck = 1'b0;
        sdata = 1'b0;
        latch = 1'b0;
    end
    // The offset keeps host edges off the system clock edges.
    task automatic send(input logic [7:0] w, input int half);
        #7;
        for (int i = 7; i >= 0; i--) begin
            sdata = w[i];
            #(half);
            sck = 1'b1;
            #(half);
            sck = 1'b0;
        end
        sdata = ~sdata;
        #(half);
        latch = 1'b1;
        #(half);
        latch = 1'b0;
        #(half);
    endtask
endmodule
`default_nettype wire

// [bench/sscl_monitor.sv]
// Checker watching the control latch pins.
`timescale 1ns/1ps
`default_nettype none
module sscl_monitor (
    input wire logic clock,
    input wire logic resetn,
    input wire logic sck_in,
    input wire logic latch_strobe_in,
    input wire logic register_clear_n,
    input wire logic output_enable_n,
    input wire logic standby_in,
    input wire logic winding_a_phase,
    input wire logic winding_a_drive,
    input wire logic winding_b_phase,
    input wire logic winding_b_drive,
    input wire logic torque_level_bit3,
    input wire logic torque_level_bit2,
    input wire logic torque_level_bit1,
    input wire logic torque_level_bit0,
    input wire logic output_stage_on,
    input wire logic chopping_oscillator,
    input wire logic cascade_data_out,
    input wire logic cascade_clock_out,
    input wire logic cascade_latch_out
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    wire [7:0] ctl = {winding_a_phase, winding_a_drive, winding_b_phase, winding_b_drive,
        torque_level_bit3, torque_level_bit2, torque_level_bit1, torque_level_bit0};
    logic [8:0] run_q;
    // Nine bits so one half period never wraps the count.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            run_q <= 9'h000;
        end else begin
            run_q <= $changed(chopping_oscillator) ? 9'h001 : run_q + 9'h001;
        end
    end
    sequence s_oe_off; output_enable_n [*5]; endsequence
    sequence s_clr_on; !register_clear_n [*5]; endsequence
    sequence s_sleep; !standby_in [*5]; endsequence
    property p_oe_gate; s_oe_off |-> ctl == 8'h00; endproperty
    a_oe_gate: assert property (p_oe_gate) else $error("control on while disabled");
    property p_clear; s_clr_on |-> ctl == 8'h00 && !cascade_data_out; endproperty
    a_clear: assert property (p_clear) else $error("register not cleared");
    property p_clk_up; $rose(sck_in) |-> ##[2:4] cascade_clock_out; endproperty
    a_clk_up: assert property (p_clk_up) else $error("clock rise not forwarded");
    property p_clk_dn; $fell(sck_in) |-> ##[2:4] !cascade_clock_out; endproperty
    a_clk_dn: assert property (p_clk_dn) else $error("clock fall not forwarded");
    property p_lat; $rose(latch_strobe_in) |-> ##[2:4] cascade_latch_out; endproperty
    a_lat: assert property (p_lat) else $error("latch not forwarded");
    property p_dout;
        $rose(cascade_data_out) |->
            !cascade_clock_out && ($past(cascade_clock_out) || $past(cascade_clock_out, 2));
    endproperty
    a_dout: assert property (p_dout) else $error("data out moved off a clock fall");
    property p_sleep; s_sleep |-> !output_stage_on && !chopping_oscillator; endproperty
    a_sleep: assert property (p_sleep) else $error("stage awake in standby");
    property p_chop;
        $fell(chopping_oscillator) && standby_in && $past(standby_in, 4) |->
            run_q >= 9'h0C7 && run_q <= 9'h0C9;
    endproperty
    a_chop: assert property (p_chop) else $error("oscillator half period wrong");
endmodule
bind sscl_top sscl_monitor u_mon (.clock(clock), .resetn(resetn), .sck_in(sck_in),
    .latch_strobe_in(latch_strobe_in), .register_clear_n(register_clear_n),
    .output_enable_n(output_enable_n), .standby_in(standby_in),
    .winding_a_phase(winding_a_phase), .winding_a_drive(winding_a_drive),
    .winding_b_phase(winding_b_phase), .winding_b_drive(winding_b_drive),
    .torque_level_bit3(torque_level_bit3), .torque_level_bit2(torque_level_bit2),
    .torque_level_bit1(torque_level_bit1), .torque_level_bit0(torque_level_bit0),
    .output_stage_on(output_stage_on), .chopping_oscillator(chopping_oscillator),
    .cascade_data_out(cascade_data_out), .cascade_clock_out(cascade_clock_out),
    .cascade_latch_out(cascade_latch_out));
`default_nettype wire

// [bench/sscl_top_tb.sv]
// Self-checking bench for the serial stepper control latch.
`timescale 1ns/1ps
`default_nettype none
module sscl_top_tb;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic register_clear_n = 1'b0;
    logic output_enable_n = 1'b1;
    logic standby_in = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    wire sck, sdata, latch, stage, cdo, log_rdy, pready, pslverr;
    wire [7:0] ctl;
    wire [31:0] prdata;
    wire [10:0] pins = {log_rdy, stage, cdo, ctl};
    int num_errors = 0;
    int compares = 0;
    int cyc = 0;
    logic [33:0] note_q[$];
    logic [33:0] note;
    logic [32:0] obs = 33'h000000000;
    logic [32:0] r;
    logic seen = 1'b0;
    always #12.5 clock = ~clock;
    sscl_host host (.sck(sck), .sdata(sdata), .latch(latch));
    sscl_top DUT (.clock(clock), .resetn(resetn), .sck_in(sck), .sdata_in(sdata),
        .register_clear_n(register_clear_n), .latch_strobe_in(latch),
        .output_enable_n(output_enable_n), .standby_in(standby_in),
        .winding_a_phase(ctl[7]), .winding_a_drive(ctl[6]), .winding_b_phase(ctl[5]),
        .winding_b_drive(ctl[4]), .torque_level_bit3(ctl[3]), .torque_level_bit2(ctl[2]),
        .torque_level_bit1(ctl[1]), .torque_level_bit0(ctl[0]), .output_stage_on(stage),
        .chopping_oscillator(), .cascade_data_out(cdo), .cascade_clock_out(),
        .cascade_latch_out(), .word_log_ready(log_rdy), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr));
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cmp_pins(input logic [10:0] e, input logic [10:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL pins exp %h got %h", e, g);
        end
    endtask
    task automatic cmp_reg(input logic [32:0] e, input logic [32:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL read exp %h got %h", e, g);
        end
    endtask
    task automatic post(input logic k, input logic [32:0] e, input logic [32:0] v);
        note_q.push_back({k, e});
        obs <= v;
        seen <= 1'b1;
        @(posedge clock);
        seen <= 1'b0;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        r = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        apb(1'b0, a, 32'h00000000);
        post(1'b1, e, r);
    endtask
    // Eight cycles cover the pin synchroniser and the output register.
    task automatic pin(input logic [10:0] e);
        repeat (8) @(posedge clock);
        post(1'b0, {22'h000000, e}, {22'h000000, pins});
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            tally_and_finish();
        end
        if (seen) begin
            note = note_q.pop_front();
            if (note[33]) cmp_reg(note[32:0], obs);
            else cmp_pins(note[10:0], obs[10:0]);
        end
    end
    initial begin
        logic [7:0] w;
        void'($urandom(76441));
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        rd(12'h000, 33'h000000002);
        rd(12'h004, 33'h000020000);
        pin(11'h400);
        $display("done defaults");
        register_clear_n <= 1'b1;
        output_enable_n <= 1'b0;
        standby_in <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            w = {4'($urandom()), 4'(i)};
            host.send(w, (i == 15) ? 300 : 100);
            pin({2'b11, w[7], w});
            rd(12'h008, {25'h0000001, w});
        end
        $display("done words");
        for (int i = 0; i < 3; i++) host.send(8'h31 + 8'(i), 100);
        pin(11'h233);
        rd(12'h008, 33'h000000131);
        rd(12'h008, 33'h000000132);
        rd(12'h004, 33'h001C3333);
        $display("done buffer");
        output_enable_n <= 1'b1;
        pin(11'h600);
        output_enable_n <= 1'b0;
        pin(11'h633);
        register_clear_n <= 1'b0;
        host.send(8'hFF, 100);
        pin(11'h600);
        register_clear_n <= 1'b1;
        // The clear pin needs its two synchroniser stages before status shows it released.
        repeat (4) @(posedge clock);
        rd(12'h004, 33'h001C0000);
        $display("done clear");
        apb(1'b1, 12'h00C, 32'h00000000);
        rd(12'h00C, 33'h100000000);
        apb(1'b1, 12'h000, 32'h00000000);
        pin(11'h400);
        apb(1'b1, 12'h000, 32'h00000002);
        rd(12'h000, 33'h000000002);
        host.send(8'hA5, 100);
        pin(11'h7A5);
        apb(1'b1, 12'h000, 32'h00000003);
        pin(11'h600);
        rd(12'h004, 33'h001C0000);
        apb(1'b1, 12'h000, 32'h00000002);
        standby_in <= 1'b0;
        pin(11'h400);
        $display("done control");
        tally_and_finish();
    end
endmodule
`default_nettype wire

// [hw/sscl_buf.v]
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none

module sscl_buf #(
    parameter WIDTH = 8
) (
    input wire clock,
    input wire resetn,
    input wire clear,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data,
    output wire full
);

    reg [WIDTH-1:0] mem_q [0:1];
    reg wr_ptr_q;
    reg rd_ptr_q;
    reg [1:0] count_q;
    wire push;
    wire pop;

    assign in_ready = (count_q != 2'h2);
    assign out_valid = (count_q != 2'h0);
    assign full = ~in_ready;
    assign out_data = mem_q[rd_ptr_q];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always @(posedge clock) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q <= 2'h0;
        end else if (clear) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            if (push && !pop) begin
                count_q <= count_q + 2'h1;
            end else if (pop && !push) begin
                count_q <= count_q - 2'h1;
            end
        end
    end

endmodule

`default_nettype wire

// [hw/sscl_regs.vh]
// Constants for the serial stepper control latch: offsets, fields, reset values and timing.
`ifndef SSCL_REGS_VH
`define SSCL_REGS_VH

`define SSCL_WORD_W 8
`define SSCL_ADDR_W 12

`define SSCL_ADDR_CTRL 12'h000
`define SSCL_ADDR_STATUS 12'h004
`define SSCL_ADDR_LOG 12'h008

`define SSCL_CTRL_SOFT_CLEAR 0
`define SSCL_CTRL_RUN_ALLOW 1
`define SSCL_CTRL_RESET 2'h2

`define SSCL_ST_STORE_LO 0
`define SSCL_ST_STORE_HI 7
`define SSCL_ST_SHIFT_LO 8
`define SSCL_ST_SHIFT_HI 15
`define SSCL_ST_LOG_VALID 16
`define SSCL_ST_OE_N 17
`define SSCL_ST_STANDBY 18
`define SSCL_ST_CLEAR_N 19
`define SSCL_ST_STAGE_ON 20
`define SSCL_ST_LOG_FULL 21

`define SSCL_LOG_VALID_BIT 8

`define SSCL_MAP_A_PHASE 7
`define SSCL_MAP_A_DRIVE 6
`define SSCL_MAP_B_PHASE 5
`define SSCL_MAP_B_DRIVE 4
`define SSCL_MAP_TORQUE_LEVEL_BIT1 3
`define SSCL_MAP_TORQUE_LEVEL_BIT2 2
`define SSCL_MAP_TORQUE_LEVEL_BIT3 1
`define SSCL_MAP_TRQ0 0

`define SSCL_LAST_STAGE 7
`define SSCL_WORD_CLEAR 8'h00
`define SSCL_DATA_ZERO 32'h00000000

`define SSCL_CLK_NS 25
`define SSCL_CHOP_HALF_NS 5000
`define SSCL_CHOP_CNT_W 8

`endif

// [hw/sscl_sync.v]
// Two-stage synchroniser for one pin, with edge detection on the synchronised level.
`timescale 1ns/1ps
`default_nettype none

module sscl_sync #(
    parameter [0:0] RST_VAL = 1'b0
) (
    input wire clock,
    input wire resetn,
    input wire pin,
    output wire level,
    output wire rise,
    output wire fall
);

    reg meta_q;
    reg sync_q;
    reg prev_q;

    // The idle level matches what an undriven pin settles to, so no false edge at release.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
            prev_q <= RST_VAL;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;

endmodule

`default_nettype wire

// [hw/sscl_top.v]
// Serial stepper control latch: shift and storage registers, cascade outputs, APB registers.
`timescale 1ns/1ps
`default_nettype none
`include "sscl_regs.vh"

module sscl_top (
    input wire clock,
    input wire resetn,
    input wire sck_in,
    input wire sdata_in,
    input wire register_clear_n,
    input wire latch_strobe_in,
    input wire output_enable_n,
    input wire standby_in,
    output reg winding_a_phase,
    output reg winding_a_drive,
    output reg winding_b_phase,
    output reg winding_b_drive,
    output reg torque_level_bit3,
    output reg torque_level_bit2,
    output reg torque_level_bit1,
    output reg torque_level_bit0,
    output reg output_stage_on,
    output reg chopping_oscillator,
    output reg cascade_data_out,
    output reg cascade_clock_out,
    output reg cascade_latch_out,
    output wire word_log_ready,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`SSCL_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr
);

    // The division is done at full width and cut to the counter on purpose.
    localparam integer CHOP_HALF_FULL = `SSCL_CHOP_HALF_NS / `SSCL_CLK_NS - 1;
    localparam [`SSCL_CHOP_CNT_W-1:0] CHOP_HALF_CYC = CHOP_HALF_FULL[`SSCL_CHOP_CNT_W-1:0];

    // Decodes a byte address into one-hot register selects.
    function [2:0] reg_sel;
        input [`SSCL_ADDR_W-1:0] addr;
        begin
            reg_sel = {addr == `SSCL_ADDR_LOG, addr == `SSCL_ADDR_STATUS,
                addr == `SSCL_ADDR_CTRL};
        end
    endfunction

    // Forces the whole control word off while the enable pin is high.
    function [`SSCL_WORD_W-1:0] gate_word;
        input oe_n;
        input [`SSCL_WORD_W-1:0] word;
        begin
            gate_word = oe_n ? `SSCL_WORD_CLEAR : word;
        end
    endfunction

    wire sck_lvl;
    wire sck_rise;
    wire sck_fall;
    wire sdata_lvl;
    wire clr_n_lvl;
    wire latch_lvl;
    wire latch_rise;
    wire oe_n_lvl;
    wire stby_lvl;

    reg [`SSCL_WORD_W-1:0] shift_q;
    reg [`SSCL_WORD_W-1:0] store_q;
    reg [1:0] ctrl_q;
    reg [`SSCL_CHOP_CNT_W-1:0] chop_cnt_q;
    reg [31:0] rdata_d;

    wire clear_act;
    wire [2:0] sel;
    wire setup_ph;
    wire access_ph;
    wire wr_en;
    wire rd_log;
    wire log_valid;
    wire log_full;
    wire [`SSCL_WORD_W-1:0] log_word;
    wire [`SSCL_WORD_W-1:0] gated_w;

    // Pin synchronisers; reset levels are the idle levels of undriven pins.
    sscl_sync #(.RST_VAL(1'b0)) u_sck (
        .clock(clock),
        .resetn(resetn),
        .pin(sck_in),
        .level(sck_lvl),
        .rise(sck_rise),
        .fall(sck_fall)
    );

    sscl_sync #(.RST_VAL(1'b0)) u_sdata (
        .clock(clock),
        .resetn(resetn),
        .pin(sdata_in),
        .level(sdata_lvl),
        .rise(),
        .fall()
    );

    sscl_sync #(.RST_VAL(1'b0)) u_clr (
        .clock(clock),
        .resetn(resetn),
        .pin(register_clear_n),
        .level(clr_n_lvl),
        .rise(),
        .fall()
    );

    sscl_sync #(.RST_VAL(1'b0)) u_latch (
        .clock(clock),
        .resetn(resetn),
        .pin(latch_strobe_in),
        .level(latch_lvl),
        .rise(latch_rise),
        .fall()
    );

    sscl_sync #(.RST_VAL(1'b1)) u_oe (
        .clock(clock),
        .resetn(resetn),
        .pin(output_enable_n),
        .level(oe_n_lvl),
        .rise(),
        .fall()
    );

    sscl_sync #(.RST_VAL(1'b0)) u_stby (
        .clock(clock),
        .resetn(resetn),
        .pin(standby_in),
        .level(stby_lvl),
        .rise(),
        .fall()
    );

    // Software clear acts like the clear pin so a stuck host can be recovered.
    assign clear_act = ~clr_n_lvl | ctrl_q[`SSCL_CTRL_SOFT_CLEAR];

    // Shift and storage registers.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            shift_q <= `SSCL_WORD_CLEAR;
            store_q <= `SSCL_WORD_CLEAR;
        end else if (clear_act) begin
            shift_q <= `SSCL_WORD_CLEAR;
            store_q <= `SSCL_WORD_CLEAR;
        end else begin
            if (sck_rise) begin
                shift_q <= {shift_q[`SSCL_WORD_W-2:0], sdata_lvl};
            end
            if (latch_rise) begin
                store_q <= shift_q;
            end
        end
    end

    // Cascade outputs; data out changes only on the falling shift clock edge or when a clear forces it low.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cascade_data_out <= 1'b0;
            cascade_clock_out <= 1'b0;
            cascade_latch_out <= 1'b0;
        end else begin
            cascade_clock_out <= sck_lvl;
            cascade_latch_out <= latch_lvl;
            if (clear_act) begin
                cascade_data_out <= 1'b0;
            end else if (sck_fall) begin
                cascade_data_out <= shift_q[`SSCL_LAST_STAGE];
            end
        end
    end

    // Parallel control outputs, gated by the enable pin.
    assign gated_w = gate_word(oe_n_lvl, store_q);

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            winding_a_phase <= 1'b0;
            winding_a_drive <= 1'b0;
            winding_b_phase <= 1'b0;
            winding_b_drive <= 1'b0;
            torque_level_bit3 <= 1'b0;
            torque_level_bit2 <= 1'b0;
            torque_level_bit1 <= 1'b0;
            torque_level_bit0 <= 1'b0;
        end else begin
            winding_a_phase <= gated_w[`SSCL_MAP_A_PHASE];
            winding_a_drive <= gated_w[`SSCL_MAP_A_DRIVE];
            winding_b_phase <= gated_w[`SSCL_MAP_B_PHASE];
            winding_b_drive <= gated_w[`SSCL_MAP_B_DRIVE];
            torque_level_bit3 <= gated_w[`SSCL_MAP_TORQUE_LEVEL_BIT1];
            torque_level_bit2 <= gated_w[`SSCL_MAP_TORQUE_LEVEL_BIT2];
            torque_level_bit1 <= gated_w[`SSCL_MAP_TORQUE_LEVEL_BIT3];
            torque_level_bit0 <= gated_w[`SSCL_MAP_TRQ0];
        end
    end

    // Chopping oscillator runs only out of standby.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            chop_cnt_q <= {`SSCL_CHOP_CNT_W{1'b0}};
            chopping_oscillator <= 1'b0;
            output_stage_on <= 1'b0;
        end else begin
            output_stage_on <= stby_lvl & ctrl_q[`SSCL_CTRL_RUN_ALLOW];
            if (!stby_lvl) begin
                chop_cnt_q <= {`SSCL_CHOP_CNT_W{1'b0}};
                chopping_oscillator <= 1'b0;
            end else if (chop_cnt_q == CHOP_HALF_CYC) begin
                chop_cnt_q <= {`SSCL_CHOP_CNT_W{1'b0}};
                chopping_oscillator <= ~chopping_oscillator;
            end else begin
                chop_cnt_q <= chop_cnt_q + {{(`SSCL_CHOP_CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // Latched words are logged for software while there is room; word_log_ready falls when full and later words are not logged.
    sscl_buf #(.WIDTH(`SSCL_WORD_W)) u_log (
        .clock(clock),
        .resetn(resetn),
        .clear(clear_act),
        .in_valid(latch_rise),
        .in_ready(word_log_ready),
        .in_data(shift_q),
        .out_valid(log_valid),
        .out_ready(rd_log),
        .out_data(log_word),
        .full(log_full)
    );

    // APB slave with no wait states; read data is prepared in the setup cycle.
    assign sel = reg_sel(paddr);
    assign setup_ph = psel & ~penable;
    assign access_ph = psel & penable;
    assign pready = 1'b1;
    assign pslverr = access_ph & ~(|sel);
    assign wr_en = access_ph & pwrite & sel[0];
    // A LOG read pops the oldest word, so software must not read it speculatively.
    assign rd_log = access_ph & ~pwrite & sel[2];

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= `SSCL_CTRL_RESET;
        end else if (wr_en) begin
            ctrl_q <= pwdata[1:0];
        end
    end

    always @* begin
        rdata_d = `SSCL_DATA_ZERO;
        if (sel[0]) begin
            rdata_d[1:0] = ctrl_q;
        end
        if (sel[1]) begin
            rdata_d[`SSCL_ST_STORE_HI:`SSCL_ST_STORE_LO] = store_q;
            rdata_d[`SSCL_ST_SHIFT_HI:`SSCL_ST_SHIFT_LO] = shift_q;
            rdata_d[`SSCL_ST_LOG_VALID] = log_valid;
            rdata_d[`SSCL_ST_OE_N] = oe_n_lvl;
            rdata_d[`SSCL_ST_STANDBY] = stby_lvl;
            rdata_d[`SSCL_ST_CLEAR_N] = clr_n_lvl;
            rdata_d[`SSCL_ST_STAGE_ON] = output_stage_on;
            rdata_d[`SSCL_ST_LOG_FULL] = log_full;
        end
        if (sel[2]) begin
            rdata_d[`SSCL_WORD_W-1:0] = log_word;
            rdata_d[`SSCL_LOG_VALID_BIT] = log_valid;
        end
    end

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            prdata <= `SSCL_DATA_ZERO;
        end else if (setup_ph && !pwrite) begin
            prdata <= rdata_d;
        end
    end

endmodule

`default_nettype wire
